// >>> mgp_glue.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Digitise command rises only after meter control outputs have settled.
// (R2) Range data shifts serially into eight bits on gated range clock edges.
// (R3) Select high gives shift bits to four port lines, low gives delimiter switches.
// (R4) New range byte differing from held byte latches the range-changed flag.
// (R5) Store phase high: meter digit address writes strobed digits into 16x4 store.
// (R6) Store phase low: port outputs address the store for processor readback.
// (R7) Six port-B outputs of the second meter port drive meter controls.
// (R8) Receive always open; transmit drive only while transmit enable is low.
// (R9) Bus output buffers are enabled only by the talker enable.
// (R10) Parity bit over eight data bits, odd or even by switch, to bus.
// (R11) Four-bit mux returns bus data or switches, select and gate controlled.
// (R12) Bus port A carries message data, port B carries bus control.
// (R13) Local lockout and remote-enable each held in a set/reset latch; local lockout is only set here, and only reset clears it.
// (R14) Received attention feeds a port strobe; mismatch with own copy sets flag.
// (R15) Bus lines are negative logic; attention low marks command bytes.
// (R16) Attention-change flag drives transfer hold on port-B bit 1.
// (R17) After reset, interface clear cannot raise the NMI for 10 ms.
// (R18) Each port adapter decodes four locations by two register selects.
// (R19) Read/write high reads a port location, low writes it.
// (R20) Port transfers happen only in the phase-two part of each cycle.
// (R21) Reset returns every port adapter register to its initial value.
// (R22) Handshake lines request interrupts; second lines also drive outputs.
// (R23) A decoded access clears the attention-change latch.
// (R24) A second decoded access clears the remote-enable latch.
// (R25) A third decoded access sets the local lockout latch.
// (R26) Each decoded strobe is an active-low pulse about one microsecond wide.
// (R27) Latches are clocked, and asynchronous bus and meter inputs are synchronised.
module mgp_glue
	import mgp_pkg::*;
#(
	parameter int IFC_HOLD = IFC_HOLD_CYC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  rstn,
	input  wire logic                  ce,
	input  wire logic [8:0]            cpu_addr,
	input  wire logic                  cpu_rw,
	input  wire logic                  cpu_vma,
	input  wire logic [7:0]            cpu_wdata,
	input  wire logic                  buffered_phase_two_clock,
	output logic [7:0]                 cpu_rdata,
	output logic                       cpu_irq_n,
	output logic                       cpu_nmi_n,
	output logic [2:0]                 latch_strobe_n,
	output logic [7:0]                 meter_control,
	output logic [5:0]                 meter_aux_control,
	output logic                       digitise_command,
	output logic                       range_changed_flag,
	input  wire logic                  range_data_serial,
	input  wire logic                  range_data_clock,
	input  wire logic [3:0]            delimiter_switches,
	input  wire logic                  store_phase,
	input  wire logic                  digit_strobe,
	input  wire logic [DIGIT_BITS-1:0] meter_digit_address,
	input  wire logic [DIGIT_BITS-1:0] meter_digit_bits,
	input  wire logic [7:0]            bus_data_in_n,
	output logic [7:0]                 bus_data_out_n,
	output logic [7:0]                 bus_data_oe,
	output logic                       bus_parity_n,
	output logic                       bus_parity_oe,
	output logic                       xcvr_transmit_n,
	output logic [7:0]                 bus_ctrl_out,
	input  wire logic                  bus_atn_n,
	input  wire logic                  bus_ren_n,
	input  wire logic                  bus_ifc_n,
	input  wire logic                  parity_select_switch,
	input  wire logic [3:0]            config_switches,
	output logic                       attention_change_flag,
	output logic                       transfer_hold,
	output logic                       local_lockout,
	output logic                       remote_enable
);
	// ***************************************************************
	// Input synchronisers
	// ***************************************************************
	localparam int SW = 23;
	logic [SW-1:0] sync1;
	logic [SW-1:0] sync2;
	logic [SW-1:0] sync3;
	// Reset to idle bus levels, so a release cannot look like an attention change
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sync1 <= SYNC_RESET;
			sync2 <= SYNC_RESET;
			sync3 <= SYNC_RESET;
		end else if (ce) begin // [R27]
			sync1 <= {meter_digit_address, meter_digit_bits, bus_data_in_n, bus_ifc_n,
				bus_ren_n, bus_atn_n, digit_strobe, store_phase, range_data_clock,
				range_data_serial};
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end
	logic       rd_serial, rd_clk_rise, stat_s, dstrobe_rise;
	logic       atn_n_s, ren_n_s, ifc_n_s;
	logic [7:0] bus_rx;
	logic [3:0] dig_bits_s, dig_addr_s;
	assign rd_serial    = sync2[0];
	assign rd_clk_rise  = sync2[1] && !sync3[1];
	assign stat_s       = sync2[2];
	assign dstrobe_rise = sync2[3] && !sync3[3];
	assign atn_n_s      = sync2[4];
	assign ren_n_s      = sync2[5];
	assign ifc_n_s      = sync2[6];
	assign bus_rx       = ~sync2[14:7]; // [R15]
	assign dig_bits_s   = sync2[18:15];
	assign dig_addr_s   = sync2[22:19];

	// ***************************************************************
	// Processor access decode
	// ***************************************************************
	mgp_cpu_if cpu ();
	logic       ph2_d;
	logic       access;
	logic [7:0] rd_bus, rd_ctl, rd_dat;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			ph2_d <= 1'b0;
		else if (ce)
			ph2_d <= buffered_phase_two_clock;
	end
	// One access per processor cycle, at the start of phase two
	assign access    = ce && cpu_vma && buffered_phase_two_clock && !ph2_d; // [R20]
	assign cpu.access = access;
	assign cpu.rw     = cpu_rw; // [R19]
	assign cpu.rs     = cpu_addr[1:0]; // [R18]
	assign cpu.wdata  = cpu_wdata;
	logic sel_bus, sel_ctl, sel_dat;
	assign sel_bus = cpu_addr[8:2] == ADDR_PORT_BUS[8:2];
	assign sel_ctl = cpu_addr[8:2] == ADDR_PORT_CTL[8:2];
	assign sel_dat = cpu_addr[8:2] == ADDR_PORT_DAT[8:2];

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn)
			cpu_rdata <= 8'h00;
		else if (access && cpu_rw) // [R19]
			cpu_rdata <= sel_bus ? rd_bus : sel_ctl ? rd_ctl : sel_dat ? rd_dat : 8'h00;
	end

	// ***************************************************************
	// Decoded latch strobes
	// ***************************************************************
	logic [2:0] hit_strobe;
	logic [7:0] strobe_cnt;
	assign hit_strobe = {cpu_addr[8:4] == ADDR_SET_LLO[8:4],
		cpu_addr[8:4] == ADDR_CLR_REN[8:4], cpu_addr[8:4] == ADDR_CLR_ATN[8:4]};
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			latch_strobe_n <= 3'h7;
			strobe_cnt     <= 8'h00;
		end else if (ce) begin
			if (access && |hit_strobe) begin // [R26]
				latch_strobe_n <= ~hit_strobe;
				strobe_cnt     <= 8'(STROBE_CYC - 1);
			end else if (strobe_cnt != 8'h00)
				strobe_cnt <= strobe_cnt - 8'h01;
			else
				latch_strobe_n <= 3'h7;
		end
	end
	logic clr_atn, clr_ren, set_llo;
	assign clr_atn = access && hit_strobe[0]; // [R23]
	assign clr_ren = access && hit_strobe[1]; // [R24]
	assign set_llo = access && hit_strobe[2]; // [R25]

	// ***************************************************************
	// Port adapters
	// ***************************************************************
	logic [7:0] bus_pa_out, bus_pa_dir, bus_pb_out, bus_pb_dir, bus_pb_in;
	logic       atn_copy, talker_drive_enable;
	logic [7:0] m1_pa_out, m1_pb_in, m3_pa_out, m3_pa_in, m3_pb_out;
	logic       m1_ca2, m1_cb2, m3_ca2;
	logic [5:0] irqs;
	logic       range_done;
	logic [7:0] shift_reg;
	logic [3:0] store_q;
	logic [3:0] mux_nibble;

	mgp_port u_bus (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .bus(cpu), .sel(sel_bus), .rdata(rd_bus),
		.pa_in(bus_rx), .pa_out(bus_pa_out), .pa_dir(bus_pa_dir), // [R12]
		.pb_in(bus_pb_in), .pb_out(bus_pb_out), .pb_dir(bus_pb_dir),
		.a_strobe(!atn_n_s), .b_strobe(!ren_n_s), // [R14]
		.a_control(atn_copy), .b_control(talker_drive_enable), .irq_a(irqs[0]), .irq_b(irqs[1])
	);
	mgp_port u_ctl (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .bus(cpu), .sel(sel_ctl), .rdata(rd_ctl),
		.pa_in(8'h00), .pa_out(m1_pa_out), .pa_dir(), .pb_in(m1_pb_in), .pb_out(),
		.pb_dir(), .a_strobe(range_done), .b_strobe(range_changed_flag),
		.a_control(m1_ca2), .b_control(m1_cb2), .irq_a(irqs[2]), .irq_b(irqs[3])
	);
	mgp_port u_dat (
		.ref_clk(ref_clk), .rstn(rstn), .ce(ce), .bus(cpu), .sel(sel_dat), .rdata(rd_dat),
		.pa_in(m3_pa_in), .pa_out(m3_pa_out), .pa_dir(), .pb_in(8'h00),
		.pb_out(m3_pb_out), .pb_dir(), .a_strobe(stat_s), .b_strobe(sync2[3]),
		.a_control(m3_ca2), .b_control(), .irq_a(irqs[4]), .irq_b(irqs[5])
	);

	// ***************************************************************
	// Meter side
	// ***************************************************************
	logic [7:0] held_range;
	logic [2:0] bit_cnt;
	logic [7:0] ctl_prev;
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			shift_reg  <= 8'h00;
			bit_cnt    <= 3'h0;
			range_done <= 1'b0;
		end else if (ce) begin
			range_done <= 1'b0;
			if (rd_clk_rise && m1_ca2) begin // [R2]
				shift_reg <= {shift_reg[6:0], rd_serial};
				bit_cnt   <= bit_cnt + 3'h1;
				range_done <= bit_cnt == 3'(RANGE_BITS - 1);
			end
		end
	end
	// Only whole bytes are compared, so a part-shifted byte cannot raise a change
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			held_range         <= 8'h00;
			range_changed_flag <= 1'b0;
		end else if (ce) begin
			if (range_done && shift_reg != held_range) // [R4]
				range_changed_flag <= 1'b1;
			else if (digitise_command)
				range_changed_flag <= 1'b0;
			if (range_done)
				held_range <= shift_reg;
		end
	end
	assign m1_pb_in = {m3_ca2 ? shift_reg[7] : delimiter_switches[3], shift_reg[6:3], // [R3]
		m3_ca2 ? shift_reg[2:0] : delimiter_switches[2:0]};

	// Control outputs are registered two cycles before the command may rise
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			meter_control     <= 8'h00;
			ctl_prev          <= 8'h00;
			digitise_command  <= 1'b0;
			meter_aux_control <= 6'h00;
		end else if (ce) begin
			meter_control     <= m1_pa_out;
			ctl_prev          <= meter_control;
			digitise_command  <= m1_cb2 && meter_control == m1_pa_out
				&& ctl_prev == meter_control; // [R1]
			meter_aux_control <= m3_pb_out[5:0]; // [R7]
		end
	end

	logic [DIGIT_BITS-1:0] digit_store [STORE_DEPTH];
	logic [3:0]            store_addr;
	assign store_addr = stat_s ? dig_addr_s : m3_pa_out[7:4]; // [R5] [R6]
	always_ff @(posedge ref_clk) begin
		if (ce && stat_s && dstrobe_rise) // [R5]
			digit_store[store_addr] <= dig_bits_s;
	end
	assign store_q  = digit_store[store_addr];
	assign m3_pa_in = {4'h0, stat_s ? 4'h0 : store_q}; // [R6]

	// ***************************************************************
	// Bus side
	// ***************************************************************
	logic [23:0] ifc_cnt;
	logic        ifc_armed;
	assign mux_nibble = bus_pb_out[3] ? (bus_pb_out[2] ? bus_rx[3:0] : config_switches)
		: 4'h0; // [R11]
	assign bus_pb_in  = {mux_nibble, 1'b0, local_lockout, transfer_hold, // [R16]
		remote_enable};
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			bus_data_out_n  <= 8'hFF;
			bus_data_oe     <= 8'h00;
			bus_parity_n    <= 1'b1;
			bus_parity_oe   <= 1'b0;
			xcvr_transmit_n <= 1'b1;
			bus_ctrl_out    <= 8'h00;
		end else if (ce) begin
			bus_data_out_n  <= ~bus_pa_out; // [R15]
			bus_data_oe     <= talker_drive_enable ? bus_pa_dir : 8'h00; // [R9]
			bus_parity_n    <= ~(^bus_pa_out ^ parity_select_switch); // [R10]
			bus_parity_oe   <= talker_drive_enable;
			xcvr_transmit_n <= !talker_drive_enable; // [R8]
			bus_ctrl_out    <= bus_pb_out & bus_pb_dir;
		end
	end
	// Set beats the decoded clear when both land together
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			attention_change_flag <= 1'b0;
			transfer_hold         <= 1'b0;
			remote_enable         <= 1'b0;
			local_lockout         <= 1'b0;
		end else if (ce) begin
			if (atn_copy != !atn_n_s) // [R14]
				attention_change_flag <= 1'b1;
			else if (clr_atn) // [R23]
				attention_change_flag <= 1'b0;
			transfer_hold <= attention_change_flag; // [R16]
			if (!ren_n_s) // [R13]
				remote_enable <= 1'b1;
			else if (clr_ren) // [R24]
				remote_enable <= 1'b0;
			if (set_llo) // [R25]
				local_lockout <= 1'b1;
		end
	end
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ifc_cnt   <= 24'h000000;
			ifc_armed <= 1'b0;
			cpu_nmi_n <= 1'b1;
			cpu_irq_n <= 1'b1;
		end else if (ce) begin
			if (!ifc_armed) begin // [R17]
				ifc_cnt   <= ifc_cnt + 24'h000001;
				ifc_armed <= ifc_cnt == 24'(IFC_HOLD - 1);
			end
			cpu_nmi_n <= !(ifc_armed && !ifc_n_s); // [R17]
			cpu_irq_n <= !(|irqs); // [R22]
		end
	end

	// ***************************************************************
	// Checks
	// ***************************************************************
	strobe_width_a: assert property (@(posedge ref_clk) disable iff (!rstn || !ce) // [R26]
		$fell(latch_strobe_n[0]) |-> !latch_strobe_n[0] [*8])
		else $error("attention clear strobe shorter than expected");
	atn_set_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R14]
		ce && atn_copy != !atn_n_s |=> attention_change_flag)
		else $error("attention mismatch did not set the flag");
	hold_follow_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R16]
		ce && attention_change_flag |=> transfer_hold && bus_pb_in[1])
		else $error("transfer hold does not follow the attention flag");
	talker_drive_enable_drive_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R9]
		|bus_data_oe |-> !xcvr_transmit_n && bus_parity_oe)
		else $error("bus driven without talker enable");
	nmi_block_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R17]
		!ifc_armed |=> cpu_nmi_n)
		else $error("interface clear reached the NMI during start-up");
	parity_val_a: assert property (@(posedge ref_clk) disable iff (!rstn || !ce) // [R10]
		1'b1 |=> bus_parity_n == !(^bus_data_out_n ^ $past(parity_select_switch)))
		else $error("bus parity bit wrong");
	range_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R4]
		ce && range_done && shift_reg != held_range |=> range_changed_flag)
		else $error("range change not flagged");
	llo_set_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R25]
		ce && set_llo |=> local_lockout ##1 local_lockout)
		else $error("local lockout not held after its strobe");
endmodule : mgp_glue
`default_nettype wire

// >>> mgp_pkg.sv
package mgp_pkg;
	// ***************************************************************
	// Clock and timing
	// ***************************************************************
	localparam int CLK_MHZ      = 200;
	localparam int STROBE_NS    = 1000;
	localparam int STROBE_CYC   = (STROBE_NS * CLK_MHZ) / 1000;
	localparam int IFC_HOLD_MS  = 10;
	localparam int IFC_HOLD_CYC = IFC_HOLD_MS * CLK_MHZ * 1000;
	localparam int RANGE_BITS   = 8;
	localparam int STORE_DEPTH  = 16;
	localparam int DIGIT_BITS   = 4;

	// ***************************************************************
	// Processor address map
	// ***************************************************************
	localparam logic [8:0] ADDR_PORT_BUS   = 9'h000;
	localparam logic [8:0] ADDR_PORT_CTL   = 9'h004;
	localparam logic [8:0] ADDR_PORT_DAT   = 9'h008;
	localparam logic [8:0] ADDR_CLR_ATN    = 9'h180;
	localparam logic [8:0] ADDR_CLR_REN    = 9'h190;
	localparam logic [8:0] ADDR_SET_LLO    = 9'h1A0;

	// ***************************************************************
	// Port adapter locations and control fields
	// ***************************************************************
	localparam logic [1:0] RS_DATA_A       = 2'h0;
	localparam logic [1:0] RS_CTRL_A       = 2'h1;
	localparam logic [1:0] RS_DATA_B       = 2'h2;
	localparam logic [1:0] RS_CTRL_B       = 2'h3;
	localparam int         CTL_IRQ_EN      = 0;
	localparam int         CTL_RISE        = 1;
	localparam int         CTL_DATA_SEL    = 2;
	localparam int         CTL_C2_LEVEL    = 3;
	localparam int         CTL_FLAG        = 7;
	localparam logic [7:0] CTL_RESET       = 8'h00;
	localparam logic [7:0] PORT_RESET      = 8'h00;
	localparam logic [22:0] SYNC_RESET     = 23'h007FF0;
endpackage : mgp_pkg

// >>> mgp_cpu_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mgp_cpu_if;
	logic       access;
	logic       rw;
	logic [1:0] rs;
	logic [7:0] wdata;
	modport host (output access, output rw, output rs, output wdata);
	modport port (input access, input rw, input rs, input wdata);
endinterface : mgp_cpu_if
`default_nettype wire

// >>> mgp_port.sv
`timescale 1ns/1ps
`default_nettype none
module mgp_port
	import mgp_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	mgp_cpu_if.port         bus,
	input  wire logic       sel,
	output logic [7:0]      rdata,
	input  wire logic [7:0] pa_in,
	output logic [7:0]      pa_out,
	output logic [7:0]      pa_dir,
	input  wire logic [7:0] pb_in,
	output logic [7:0]      pb_out,
	output logic [7:0]      pb_dir,
	input  wire logic       a_strobe,
	input  wire logic       b_strobe,
	output logic            a_control,
	output logic            b_control,
	output logic            irq_a,
	output logic            irq_b
);
	logic [7:0] out_r [2];
	logic [7:0] dir_r [2];
	logic [7:0] ctl_r [2];
	logic       flag  [2];
	logic [7:0] pins  [2];
	logic       c1    [2];
	logic [7:0] side_rd [2];

	assign pins[0] = pa_in;
	assign pins[1] = pb_in;
	assign c1[0]   = a_strobe;
	assign c1[1]   = b_strobe;

	// ***************************************************************
	// One data/direction/control group per side
	// ***************************************************************
	for (genvar s = 0; s < 2; s++) begin : g_side
		logic       c1_d;
		logic       edge_seen;
		logic       hit_data;
		logic       hit_ctl;
		assign hit_data  = sel && bus.access && bus.rs == 2'(2 * s); // [R18]
		assign hit_ctl   = sel && bus.access && bus.rs == 2'(2 * s + 1); // [R18]
		assign edge_seen = ctl_r[s][CTL_RISE] ? (c1[s] && !c1_d) : (!c1[s] && c1_d);
		assign side_rd[s] = ctl_r[s][CTL_DATA_SEL] ? ((pins[s] & ~dir_r[s]) | (out_r[s] & dir_r[s]))
			: dir_r[s];
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin // [R21]
				out_r[s] <= PORT_RESET;
				dir_r[s] <= PORT_RESET;
				ctl_r[s] <= CTL_RESET;
				flag[s]  <= 1'b0;
				c1_d     <= 1'b0;
			end else if (ce) begin
				c1_d <= c1[s];
				if (hit_data && !bus.rw && ctl_r[s][CTL_DATA_SEL]) // [R19]
					out_r[s] <= bus.wdata;
				if (hit_data && !bus.rw && !ctl_r[s][CTL_DATA_SEL])
					dir_r[s] <= bus.wdata;
				if (hit_ctl && !bus.rw)
					ctl_r[s] <= {1'b0, bus.wdata[6:0]};
				// A strobe edge in the reading cycle survives the read
				if (edge_seen) // [R22]
					flag[s] <= 1'b1;
				else if (hit_data && bus.rw && ctl_r[s][CTL_DATA_SEL])
					flag[s] <= 1'b0;
			end
		end
	end

	always_comb begin
		unique case (bus.rs)
			RS_DATA_A: rdata = side_rd[0]; // [R19]
			RS_CTRL_A: rdata = {flag[0], ctl_r[0][6:0]};
			RS_DATA_B: rdata = side_rd[1];
			RS_CTRL_B: rdata = {flag[1], ctl_r[1][6:0]};
		endcase
	end

	assign pa_out    = out_r[0];
	assign pa_dir    = dir_r[0];
	assign pb_out    = out_r[1];
	assign pb_dir    = dir_r[1];
	assign a_control = ctl_r[0][CTL_C2_LEVEL]; // [R22]
	assign b_control = ctl_r[1][CTL_C2_LEVEL];
	assign irq_a     = flag[0] && ctl_r[0][CTL_IRQ_EN]; // [R22]
	assign irq_b     = flag[1] && ctl_r[1][CTL_IRQ_EN];

	port_flag_a: assert property (@(posedge ref_clk) disable iff (!rstn) // [R22]
		ce && g_side[0].edge_seen |=> flag[0])
		else $error("port A strobe edge did not raise its flag");
endmodule : mgp_port
`default_nettype wire

// >>> mgp_meter_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgp_meter_model (
	input  wire logic       ref_clk,
	input  wire logic       start,
	input  wire logic [7:0] range_byte,
	output logic            range_data_serial,
	output logic            range_data_clock
);
	// ***************************************************************
	// Serial range sender
	// ***************************************************************
	// Clock rests low between frames; released data shows its inverse
	initial begin
		range_data_serial = 1'b0;
		range_data_clock = 1'b0;
		forever begin
			@(posedge ref_clk iff start);
			for (int i = 7; i >= 0; i--) begin
				@(negedge ref_clk) range_data_serial = range_byte[i];
				repeat (4) @(negedge ref_clk);
				range_data_clock = 1'b1;
				repeat (4) @(negedge ref_clk);
				range_data_clock = 1'b0;
			end
			range_data_serial = ~range_data_serial;
		end
	end
endmodule : mgp_meter_model
`default_nettype wire

// >>> meter_gpib_port_glue_bench.sv
`timescale 1ns/1ps
`default_nettype none
module meter_gpib_port_glue_bench;
	import mgp_pkg::*;
	logic       ref_clk, rstn, ce, rw, vma, ph2, rd_ser, rd_clk, st_ph, dstb, go;
	logic       atn_n, ren_n, ifc_n, par_sw, irq_n, nmi_n, dig, rchg, par_n, par_oe;
	logic       xmit_n, atn_f, hold, llo, ren;
	logic [8:0] addr;
	logic [7:0] wd, rd, mctl, bdo, boe, bctl, bdi_n;
	logic [5:0] aux;
	logic [3:0] dlm, cfg, dadr, dbits;
	logic [2:0] stb_n;
	int         error_cnt, n_tests;

	mgp_glue #(.IFC_HOLD(50)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .ce(ce),
		.cpu_addr(addr), .cpu_rw(rw), .cpu_vma(vma), .cpu_wdata(wd),
		.buffered_phase_two_clock(ph2), .cpu_rdata(rd), .cpu_irq_n(irq_n), .cpu_nmi_n(nmi_n),
		.latch_strobe_n(stb_n), .meter_control(mctl), .meter_aux_control(aux),
		.digitise_command(dig), .range_changed_flag(rchg), .range_data_serial(rd_ser),
		.range_data_clock(rd_clk), .delimiter_switches(dlm), .store_phase(st_ph),
		.digit_strobe(dstb), .meter_digit_address(dadr), .meter_digit_bits(dbits),
		.bus_data_in_n(bdi_n), .bus_data_out_n(bdo), .bus_data_oe(boe), .bus_parity_n(par_n),
		.bus_parity_oe(par_oe), .xcvr_transmit_n(xmit_n), .bus_ctrl_out(bctl),
		.bus_atn_n(atn_n), .bus_ren_n(ren_n), .bus_ifc_n(ifc_n), .parity_select_switch(par_sw),
		.config_switches(cfg), .attention_change_flag(atn_f), .transfer_hold(hold),
		.local_lockout(llo), .remote_enable(ren));
	mgp_meter_model i_meter (.ref_clk(ref_clk), .start(go), .range_byte(8'hA5),
		.range_data_serial(rd_ser), .range_data_clock(rd_clk));

	// ***************************************************************
	// Shared tasks
	// ***************************************************************
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One access per phase-two rise; read data lands one cycle later
	task automatic acc(input logic [8:0] a, input logic r, input logic [7:0] d);
		@(negedge ref_clk) {addr, rw, wd, vma, ph2} = {a, r, d, 2'b11};
		@(negedge ref_clk) {vma, ph2} = 2'b00;
		@(posedge ref_clk) #1;
	endtask : acc
	task automatic do_reset;
		@(negedge ref_clk) rstn = 1'b0;
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
	endtask : do_reset
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results

	// ***************************************************************
	// Scenarios
	// ***************************************************************
	task automatic t_reset;
		chk("irq_n", 1, irq_n);
		chk("xmit_n", 1, xmit_n);
		chk("oe", 0, {boe, par_oe});
		chk("stb_n", 7, stb_n);
	endtask : t_reset
	task automatic t_port;
		acc(ADDR_PORT_CTL, 0, 8'hFF);
		acc(ADDR_PORT_CTL + 9'h001, 0, 8'h04);
		acc(ADDR_PORT_CTL, 0, 8'h5A);
		chk("mctl", 8'h5A, mctl);
		acc(ADDR_PORT_CTL + 9'h001, 1, 8'h00);
		chk("ctl_a", 8'h04, rd);
		acc(9'h0F0, 1, 8'h00);
		chk("unmapped", 8'h00, rd);
	endtask : t_port
	task automatic t_strobe;
		int n;
		// The access returns one cycle into the pulse
		n = 1;
		acc(ADDR_SET_LLO, 0, 8'h00);
		chk("llo", 1, llo);
		while (stb_n[2] === 1'b0 && n < 400) begin
			@(posedge ref_clk) #1;
			n++;
		end
		chk("stb_width", STROBE_CYC, n);
	endtask : t_strobe
	task automatic t_atn;
		@(negedge ref_clk) {atn_n, ren_n} = 2'b00;
		repeat (6) @(negedge ref_clk);
		chk("atn_flag", 1, atn_f);
		chk("hold", 1, hold);
		chk("ren", 1, ren);
		acc(ADDR_PORT_BUS + 9'h001, 0, 8'h08);
		acc(ADDR_PORT_BUS, 0, 8'hFF);
		acc(ADDR_PORT_BUS + 9'h001, 0, 8'h0C);
		acc(ADDR_PORT_BUS, 0, 8'h31);
		acc(ADDR_PORT_BUS + 9'h003, 0, 8'h08);
		acc(ADDR_CLR_ATN, 0, 8'h00);
		@(posedge ref_clk) #1;
		chk("atn_clr", 0, atn_f);
		chk("bus_out", 16'hCEFF, {bdo, boe});
		chk("xmit_par_oe", 2'b01, {xmit_n, par_oe});
		chk("parity", 0, par_n);
		@(negedge ref_clk) {par_sw, ren_n} = 2'b11;
		repeat (8) @(negedge ref_clk);
		chk("parity_sw", 1, par_n);
		acc(ADDR_CLR_REN, 0, 8'h00);
		chk("ren_clr", 0, ren);
		acc(ADDR_PORT_BUS + 9'h003, 0, 8'h0C);
		acc(ADDR_PORT_BUS + 9'h002, 0, 8'h08);
		acc(ADDR_PORT_BUS + 9'h002, 1, 8'h00);
		chk("bus_pb", 8'h64, rd);
	endtask : t_atn
	task automatic t_range;
		acc(ADDR_PORT_DAT + 9'h001, 0, 8'h08);
		acc(ADDR_PORT_CTL + 9'h001, 0, 8'h0D);
		acc(ADDR_PORT_CTL + 9'h003, 0, 8'h04);
		@(negedge ref_clk) go = 1'b1;
		@(negedge ref_clk) go = 1'b0;
		repeat (90) @(negedge ref_clk);
		chk("rchg", 1, rchg);
		chk("irq_n", 0, irq_n);
		acc(ADDR_PORT_CTL + 9'h002, 1, 8'h00);
		chk("range", 8'hA5, rd);
		acc(ADDR_PORT_DAT + 9'h001, 0, 8'h00);
		acc(ADDR_PORT_CTL + 9'h002, 1, 8'h00);
		chk("delim", 8'hA2, rd);
		acc(ADDR_PORT_CTL + 9'h003, 0, 8'h0C);
		repeat (4) @(negedge ref_clk);
		chk("dig", 1, dig);
		chk("rchg_clr", 0, rchg);
	endtask : t_range
	task automatic t_store;
		@(negedge ref_clk) {st_ph, dadr, dbits} = 9'h139;
		@(negedge ref_clk) dstb = 1'b1;
		repeat (4) @(negedge ref_clk);
		{st_ph, dstb} = 2'b00;
		acc(ADDR_PORT_DAT + 9'h003, 0, 8'h04);
		acc(ADDR_PORT_DAT + 9'h002, 0, 8'h2A);
		acc(ADDR_PORT_DAT + 9'h001, 0, 8'h04);
		chk("aux", 6'h2A, aux);
		acc(ADDR_PORT_DAT, 0, 8'h30);
		acc(ADDR_PORT_DAT, 1, 8'h00);
		chk("store", 8'h09, rd);
	endtask : t_store
	task automatic t_ifc;
		@(negedge ref_clk) {atn_n, ren_n, ifc_n} = 3'b110;
		do_reset();
		repeat (40) @(negedge ref_clk);
		chk("nmi_early", 1, nmi_n);
		repeat (20) @(negedge ref_clk);
		chk("nmi_late", 0, nmi_n);
	endtask : t_ifc

	// ***************************************************************
	// Clock, stimulus and watchdog
	// ***************************************************************
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		{rstn, ce, rw, vma, ph2, st_ph, dstb, go, par_sw} = 9'h0C0;
		{atn_n, ren_n, ifc_n, addr, wd, bdi_n} = {3'h7, 9'h000, 8'h00, 8'hFF};
		{dlm, cfg, dadr, dbits} = 16'hA600;
		error_cnt = 0;
		n_tests = 0;
		repeat (5) @(negedge ref_clk);
		rstn = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_reset();
		t_port();
		t_strobe();
		t_atn();
		t_range();
		t_store();
		t_ifc();
		results();
	end
	// Whole sequence needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		error_cnt++;
		results();
	end
endmodule : meter_gpib_port_glue_bench
`default_nettype wire
